// [iab_params.svh]
`ifndef IAB_PARAMS_SVH
`define IAB_PARAMS_SVH

// register offsets
`define IAB_OFF_IND_CTL 8'hb0
`define IAB_OFF_IND_OFS 8'hb1
`define IAB_OFF_IND_DAT 8'hb2
`define IAB_OFF_ST_CTL 8'hb3
`define IAB_OFF_STRAP 8'hb8

// indirect control fields
`define IAB_SEL_MSB 5
`define IAB_SEL_LSB 2
`define IAB_AINC_BIT 1
`define IAB_PREF_BIT 0
`define IAB_IND_CTL_RST 8'h00
`define IAB_IND_OFS_RST 8'h00
`define IAB_IND_DAT_RST 8'h00

// self-test control fields
`define IAB_OMODE_MSB 7
`define IAB_OMODE_LSB 6
`define IAB_RSV_MSB 5
`define IAB_RSV_LSB 4
`define IAB_CSRC_BIT 3
`define IAB_CLK_MSB 2
`define IAB_CLK_LSB 1
`define IAB_EN_BIT 0
`define IAB_ST_CTL_RST 8'h08

// remote serializer clock source offset
`define IAB_SER_CLK_OFS 8'h14

// strap status fields
`define IAB_ADONE_BIT 7
`define IAB_ADDR_MSB 6
`define IAB_ADDR_LSB 4
`define IAB_MDONE_BIT 3
`define IAB_MODE_MSB 2
`define IAB_MODE_LSB 0

`endif

// [iab_pkg.sv]
package iab_pkg;
    typedef enum logic [3:0] {
        IAB_TGT_PORT0 = 4'h1,
        IAB_TGT_PORT1 = 4'h2,
        IAB_TGT_SHARED = 4'h5,
        IAB_TGT_BOTH = 4'h6
    } iab_target_e;

    typedef enum logic [1:0] {
        IAB_OM_IDLE = 2'h0,
        IAB_OM_ALT = 2'h1,
        IAB_OM_DATA = 2'h2
    } iab_omode_e;

    typedef logic [7:0] iab_byte_t;
endpackage

// [iab_sync3.sv]
`timescale 1ns/1ps
`include "iab_params.svh"

// three-stage synchroniser; output moves only when stages two and three agree
module iab_sync3 #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    wire [W-1:0] nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            q_ff <= '0;
        end
        else
        begin
            s1_ff <= d_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff <= nxt_q;
        end
    end

    assign q_o = q_ff;
endmodule

// [iab_strap.sv]
`timescale 1ns/1ps
`include "iab_params.svh"

// latches a strap decode once its done input is seen, and holds it
module iab_strap (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [2:0] value_i,
    input wire logic done_i,
    output logic [2:0] value_o,
    output logic done_o
);
    logic [2:0] value_ff;
    logic done_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            value_ff <= 3'h0;
            done_ff <= 1'b0;
        end
        else if (done_i && !done_ff)
        begin
            value_ff <= value_i;
            done_ff <= 1'b1;
        end
    end

    assign value_o = value_ff;
    assign done_o = done_ff;
endmodule

// [iab_indirect_bist.sv]
// Behaviour
// - target select bits 5:2 steer indirect accesses: 1 port 0, 2 port 1, 5 shared, 6 write to both ports.
// - with auto-increment set the offset grows by one after each indirect read or write to target code 1, 2, 5 or 6.
// - with the prefetch bit set a write of the offset register strobes a read to the selected block for target code 1, 2 or 5.
// - with prefetch and auto-increment both set each data-port read to target code 1, 2 or 5 is followed by a read strobe.
// - the offset register holds an 8-bit offset used for every indirect access.
// - a data-port write writes the byte at the current offset of the selected block.
// - a data-port read returns the selected block register at the current offset.
// - the self-test output mode field picks no toggle, alternating toggle or data toggle.
// - config source resets to one so the pin sets enable; cleared, the enable bit takes over; the clock bits always apply.
// - when self-test is enabled the clock source bits are sent to remote serializer offset 0x14.
// - bit 7 of strap status reads one once the address strap decode has been latched.
// - bits 6:4 of strap status show the address strap decode, read-only.
// - bits 2:0 show the mode strap decode and bit 3 flags it latched.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "iab_params.svh"

module iab_indirect_bist (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output iab_pkg::iab_byte_t reg_rdata_o,
    // indirect target blocks, index 0 port 0, 1 port 1, 2 shared
    output logic [2:0] tgt_wr_o,
    output logic [2:0] tgt_rd_o,
    output iab_pkg::iab_byte_t tgt_addr_o,
    output iab_pkg::iab_byte_t tgt_wdata_o,
    input wire logic [7:0] tgt_rdata0_i,
    input wire logic [7:0] tgt_rdata1_i,
    input wire logic [7:0] tgt_rdata2_i,
    // self-test pins and setup
    input wire logic st_pin_en_i,
    input wire logic st_data_i,
    output logic st_enable_o,
    output logic [1:0] st_clock_select_o,
    output logic st_out_toggle_o,
    // forwarded write toward the remote serializer
    output logic ser_wr_o,
    output iab_pkg::iab_byte_t ser_addr_o,
    output iab_pkg::iab_byte_t ser_wdata_o,
    // strap decodes from the pin-decode logic
    input wire logic [2:0] addr_strap_i,
    input wire logic addr_strap_done_i,
    input wire logic [2:0] mode_strap_i,
    input wire logic mode_strap_done_i
);
    import iab_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    iab_byte_t ind_ctl_ff;
    iab_byte_t ind_ofs_ff;
    iab_byte_t ind_dat_ff;
    iab_byte_t st_ctl_ff;
    iab_byte_t rdata_ff;
    logic pref_ff;
    logic toggle_ff;
    logic st_en_d_ff;
    logic ser_wr_ff;
    iab_byte_t ser_wdata_ff;

    wire hit_ctl = (reg_addr_i == `IAB_OFF_IND_CTL);
    wire hit_ofs = (reg_addr_i == `IAB_OFF_IND_OFS);
    wire hit_dat = (reg_addr_i == `IAB_OFF_IND_DAT);
    wire hit_st = (reg_addr_i == `IAB_OFF_ST_CTL);
    wire hit_strap = (reg_addr_i == `IAB_OFF_STRAP);

    ////////////////////////////////////////////////////////////////////////////
    // target decode

    wire [3:0] indirect_target_select = ind_ctl_ff[`IAB_SEL_MSB:`IAB_SEL_LSB];
    wire indirect_auto_increment = ind_ctl_ff[`IAB_AINC_BIT];
    wire indirect_prefetch_read = ind_ctl_ff[`IAB_PREF_BIT];

    wire sel_p0 = (indirect_target_select == IAB_TGT_PORT0);
    wire sel_p1 = (indirect_target_select == IAB_TGT_PORT1);
    wire sel_sh = (indirect_target_select == IAB_TGT_SHARED);
    wire sel_both = (indirect_target_select == IAB_TGT_BOTH);
    wire sel_valid = sel_p0 | sel_p1 | sel_sh | sel_both;
    wire [2:0] wr_mask = {sel_sh, sel_p1 | sel_both, sel_p0 | sel_both};
    // both-ports code is write only, so reads see nothing there
    wire [2:0] rd_mask = {sel_sh, sel_p1, sel_p0};

    wire dat_wr = reg_wr_i && hit_dat;
    wire dat_rd = reg_rd_i && hit_dat;
    wire ofs_wr = reg_wr_i && hit_ofs;

    ////////////////////////////////////////////////////////////////////////////
    // indirect access

    assign tgt_wr_o = dat_wr ? wr_mask : 3'h0;
    assign tgt_addr_o = ind_ofs_ff;
    // strobe cycle passes the new byte through, so the target never latches the stale one
    assign tgt_wdata_o = dat_wr ? reg_wdata_i : ind_dat_ff;

    wire nxt_pref = indirect_prefetch_read &&
                    (ofs_wr || (dat_rd && indirect_auto_increment && sel_valid));
    assign tgt_rd_o = pref_ff ? rd_mask : 3'h0;

    wire [7:0] ind_rd_val = sel_p0 ? tgt_rdata0_i :
                            sel_p1 ? tgt_rdata1_i :
                            sel_sh ? tgt_rdata2_i : 8'h00;

    wire ind_done = (dat_wr || dat_rd) && sel_valid && indirect_auto_increment;
    wire [7:0] nxt_ofs = ofs_wr ? reg_wdata_i :
                         ind_done ? 8'(ind_ofs_ff + 8'h01) : ind_ofs_ff;

    // data register keeps the written byte driving the target data lines after the strobe
    wire [7:0] nxt_dat = dat_wr ? reg_wdata_i : ind_dat_ff;

    ////////////////////////////////////////////////////////////////////////////
    // self-test

    wire [1:0] self_test_output_mode = st_ctl_ff[`IAB_OMODE_MSB:`IAB_OMODE_LSB];
    wire self_test_config_source = st_ctl_ff[`IAB_CSRC_BIT];
    wire [1:0] self_test_clock_select = st_ctl_ff[`IAB_CLK_MSB:`IAB_CLK_LSB];
    wire self_test_enable = st_ctl_ff[`IAB_EN_BIT];

    wire st_pin_en_s;
    wire st_data_s;

    iab_sync3 #(
        .W(2)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .d_i({st_pin_en_i, st_data_i}),
        .q_o({st_pin_en_s, st_data_s})
    );

    wire st_en_eff = self_test_config_source ? st_pin_en_s : self_test_enable;

    wire nxt_toggle = !st_en_eff ? 1'b0 :
                      (self_test_output_mode == IAB_OM_IDLE) ? 1'b0 :
                      (self_test_output_mode == IAB_OM_ALT) ? !toggle_ff : st_data_s;

    wire nxt_ser_wr = st_en_eff && !st_en_d_ff;
    // value 3 passes unchanged; software keeps it away from older serializers
    wire [7:0] nxt_ser_wdata = {6'h00, self_test_clock_select};

    wire [7:0] nxt_st = reg_wr_i && hit_st ? reg_wdata_i : st_ctl_ff;

    ////////////////////////////////////////////////////////////////////////////
    // strap status

    wire [2:0] addr_val;
    wire addr_done;
    wire [2:0] mode_val;
    wire mode_done;

    iab_strap u_addr_strap (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .value_i(addr_strap_i),
        .done_i(addr_strap_done_i),
        .value_o(addr_val),
        .done_o(addr_done)
    );

    iab_strap u_mode_strap (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .value_i(mode_strap_i),
        .done_i(mode_strap_done_i),
        .value_o(mode_val),
        .done_o(mode_done)
    );

    wire [7:0] strap_decode_status = {addr_done, addr_val, mode_done, mode_val};

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    wire [7:0] nxt_rdata = !reg_rd_i ? 8'h00 :
                           hit_ctl ? {2'b00, ind_ctl_ff[5:0]} :
                           hit_ofs ? ind_ofs_ff :
                           hit_dat ? ind_rd_val :
                           hit_st ? st_ctl_ff :
                           hit_strap ? strap_decode_status : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // state

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ind_ctl_ff <= `IAB_IND_CTL_RST;
            ind_ofs_ff <= `IAB_IND_OFS_RST;
            ind_dat_ff <= `IAB_IND_DAT_RST;
            st_ctl_ff <= `IAB_ST_CTL_RST;
            rdata_ff <= 8'h00;
            pref_ff <= 1'b0;
            toggle_ff <= 1'b0;
            st_en_d_ff <= 1'b0;
            ser_wr_ff <= 1'b0;
            ser_wdata_ff <= 8'h00;
        end
        else
        begin
            if (reg_wr_i && hit_ctl)
                ind_ctl_ff <= {2'b00, reg_wdata_i[5:0]};
            ind_ofs_ff <= nxt_ofs;
            ind_dat_ff <= nxt_dat;
            st_ctl_ff <= nxt_st;
            rdata_ff <= nxt_rdata;
            pref_ff <= nxt_pref;
            toggle_ff <= nxt_toggle;
            st_en_d_ff <= st_en_eff;
            ser_wr_ff <= nxt_ser_wr;
            if (nxt_ser_wr)
                ser_wdata_ff <= nxt_ser_wdata;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign st_enable_o = st_en_eff;
    assign st_clock_select_o = self_test_clock_select;
    assign st_out_toggle_o = toggle_ff;
    assign ser_wr_o = ser_wr_ff;
    assign ser_addr_o = `IAB_SER_CLK_OFS;
    assign ser_wdata_o = ser_wdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    reserved_no_wr_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !sel_valid |-> tgt_wr_o == 3'h0)
        else $error("write strobe under reserved target");

    both_ports_wr_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (dat_wr && sel_both) |-> tgt_wr_o == 3'b011)
        else $error("dual-port write did not hit both ports");

    auto_inc_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (dat_rd && sel_valid && indirect_auto_increment && !ofs_wr)
        |=> ind_ofs_ff == 8'($past(ind_ofs_ff) + 8'h01))
        else $error("offset did not advance");

    ofs_pref_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (ofs_wr && indirect_prefetch_read && sel_p0) |=> tgt_rd_o == 3'b001)
        else $error("no prefetch strobe after offset write");

    rd_pref_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (dat_rd && indirect_prefetch_read && indirect_auto_increment && sel_sh) |=> tgt_rd_o == 3'b100)
        else $error("no prefetch strobe after data read");

    data_wr_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        dat_wr |-> tgt_wdata_o == reg_wdata_i)
        else $error("data port byte not on target lines at strobe");

    data_hold_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (dat_wr ##1 !dat_wr) |-> tgt_wdata_o == $past(reg_wdata_i))
        else $error("data port byte not held");

    reserved_rd_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (dat_rd && !sel_valid) |=> reg_rdata_o == 8'h00)
        else $error("reserved target read not zero");

    ser_fwd_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(st_en_eff) |=> ser_wr_o && ser_wdata_o[1:0] == $past(self_test_clock_select))
        else $error("clock source not forwarded");

    idle_mode_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (self_test_output_mode == IAB_OM_IDLE) |=> !st_out_toggle_o)
        else $error("toggle seen in idle mode");

    strap_rd_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_rd_i && hit_strap) |=> reg_rdata_o[6:4] == $past(addr_val) && reg_rdata_o[7] == $past(addr_done))
        else $error("strap status mismatch");
endmodule

// [test_iab_indirect_bist.sv]
`timescale 1ns/1ps
`include "iab_params.svh"

module test_iab_indirect_bist;
    import iab_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic st_pin_en_i = 1'b0;
    logic st_data_i = 1'b0;
    logic [2:0] addr_strap_i = 3'h5;
    logic addr_strap_done_i = 1'b0;
    logic [2:0] mode_strap_i = 3'h3;
    logic mode_strap_done_i = 1'b0;
    iab_byte_t reg_rdata_o;
    iab_byte_t tgt_addr_o;
    iab_byte_t tgt_wdata_o;
    iab_byte_t ser_addr_o;
    iab_byte_t ser_wdata_o;
    logic [2:0] tgt_wr_o;
    logic [2:0] tgt_rd_o;
    logic st_enable_o;
    logic [1:0] st_clock_select_o;
    logic st_out_toggle_o;
    logic ser_wr_o;
    logic [7:0] tgt_rdata0_i;
    logic [7:0] tgt_rdata1_i;
    logic [7:0] tgt_rdata2_i;
    logic [2:0] wr_mask;
    logic [7:0] wr_ofs;
    logic [7:0] wr_dat;
    logic [2:0] after;
    logic [7:0] rd_val;
    int fail_count = 0;
    int n_tests = 0;

    // distinct contents per block so a wrong steering shows up
    assign tgt_rdata0_i = tgt_addr_o ^ 8'h5a;
    assign tgt_rdata1_i = tgt_addr_o ^ 8'ha5;
    assign tgt_rdata2_i = tgt_addr_o + 8'h33;

    iab_indirect_bist u_iab_indirect_bist (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .tgt_wr_o(tgt_wr_o), .tgt_rd_o(tgt_rd_o), .tgt_addr_o(tgt_addr_o), .tgt_wdata_o(tgt_wdata_o),
        .tgt_rdata0_i(tgt_rdata0_i), .tgt_rdata1_i(tgt_rdata1_i), .tgt_rdata2_i(tgt_rdata2_i),
        .st_pin_en_i(st_pin_en_i), .st_data_i(st_data_i), .st_enable_o(st_enable_o),
        .st_clock_select_o(st_clock_select_o), .st_out_toggle_o(st_out_toggle_o), .ser_wr_o(ser_wr_o),
        .ser_addr_o(ser_addr_o), .ser_wdata_o(ser_wdata_o), .addr_strap_i(addr_strap_i),
        .addr_strap_done_i(addr_strap_done_i), .mode_strap_i(mode_strap_i),
        .mode_strap_done_i(mode_strap_done_i));

    initial
    begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // sample 1 ns after the edges so registered outputs have landed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        #1;
        wr_mask = tgt_wr_o;
        wr_ofs = tgt_addr_o;
        wr_dat = tgt_wdata_o;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        #1;
        after = tgt_rd_o;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        rd_val = reg_rdata_o;
        after = tgt_rd_o;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] offs [5] = '{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb8};
        logic [7:0] vals [5] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
        for (int i = 0; i < 5; i++)
        begin
            rd(offs[i]);
            chk(rd_val, vals[i]);
        end
        chk(ser_addr_o, 8'h14);
        wr(8'h50, 8'h77);
        rd(8'h50);
        chk(rd_val, 8'h00);
        wr(8'hb0, 8'hff);
        rd(8'hb0);
        chk(rd_val, 8'h3f);
        wr(8'hb1, 8'ha5);
        rd(8'hb1);
        chk(rd_val, 8'ha5);
    endtask

    task automatic t_write;
        logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h3};
        logic [2:0] masks [5] = '{3'b001, 3'b010, 3'b100, 3'b011, 3'b000};
        for (int i = 0; i < 5; i++)
        begin
            wr(8'hb0, {2'b00, codes[i], 2'b10});
            wr(8'hb1, 8'h10);
            wr(8'hb2, 8'hc0 + 8'(i));
            chk({5'h00, wr_mask}, {5'h00, masks[i]});
            chk(wr_ofs, 8'h10);
            chk(wr_dat, 8'hc0 + 8'(i));
            chk(tgt_wdata_o, 8'hc0 + 8'(i));
            rd(8'hb1);
            chk(rd_val, (i < 4) ? 8'h11 : 8'h10);
        end
    endtask

    task automatic t_read;
        wr(8'hb0, 8'h0b);
        wr(8'hb1, 8'h20);
        chk({5'h00, after}, 8'h02);
        chk(tgt_addr_o, 8'h20);
        rd(8'hb2);
        chk(rd_val, 8'h20 ^ 8'ha5);
        chk({5'h00, after}, 8'h02);
        rd(8'hb2);
        chk(rd_val, 8'h21 ^ 8'ha5);
        wr(8'hb0, 8'h06);
        wr(8'hb1, 8'h30);
        chk({5'h00, after}, 8'h00);
        rd(8'hb2);
        chk(rd_val, 8'h30 ^ 8'h5a);
        chk({5'h00, after}, 8'h00);
        wr(8'hb0, 8'h15);
        wr(8'hb1, 8'h40);
        chk({5'h00, after}, 8'h04);
        rd(8'hb2);
        chk(rd_val, 8'h73);
        chk({5'h00, after}, 8'h00);
        wr(8'hb0, 8'h0f);
        rd(8'hb2);
        chk(rd_val, 8'h00);
        chk({5'h00, after}, 8'h00);
        rd(8'hb1);
        chk(rd_val, 8'h40);
        wr(8'hb0, 8'h1a);
        rd(8'hb2);
        chk(rd_val, 8'h00);
    endtask

    task automatic t_selftest;
        int pulses;
        logic s0;
        // clock source 3 never chosen here
        wr(8'hb3, 8'h04);
        chk({7'h00, st_enable_o}, 8'h00);
        chk({6'h00, st_clock_select_o}, 8'h02);
        wr(8'hb3, 8'h05);
        pulses = 0;
        repeat (6)
        begin
            if (ser_wr_o === 1'b1)
            begin
                pulses++;
                chk(ser_wdata_o, 8'h02);
                chk(ser_addr_o, 8'h14);
            end
            cycles(1);
        end
        chk(8'(pulses), 8'h01);
        chk({7'h00, st_enable_o}, 8'h01);
        s0 = st_out_toggle_o;
        cycles(1);
        chk({7'h00, st_out_toggle_o}, {7'h00, s0});
        wr(8'hb3, 8'h45);
        s0 = st_out_toggle_o;
        cycles(1);
        chk({7'h00, st_out_toggle_o}, {7'h00, ~s0});
        wr(8'hb3, 8'h85);
        st_data_i <= 1'b1;
        cycles(6);
        chk({7'h00, st_out_toggle_o}, 8'h01);
        st_data_i <= 1'b0;
        cycles(6);
        chk({7'h00, st_out_toggle_o}, 8'h00);
        wr(8'hb3, 8'h08);
        st_pin_en_i <= 1'b1;
        cycles(6);
        chk({7'h00, st_enable_o}, 8'h01);
        st_pin_en_i <= 1'b0;
        cycles(6);
        chk({7'h00, st_enable_o}, 8'h00);
    endtask

    task automatic t_strap;
        addr_strap_done_i <= 1'b1;
        mode_strap_done_i <= 1'b1;
        cycles(6);
        rd(8'hb8);
        chk(rd_val, 8'hdb);
        addr_strap_i <= 3'h0;
        mode_strap_i <= 3'h0;
        cycles(6);
        wr(8'hb8, 8'h00);
        rd(8'hb8);
        chk(rd_val, 8'hdb);
        chk(rd_val & 8'h0f, 8'h0b);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_write();
        t_read();
        t_selftest();
        t_strap();
        end_of_test();
    end

    // whole run is well under a thousand cycles
    initial
    begin
        #100us;
        fail_count++;
        end_of_test();
    end
endmodule
